// ===== logic/jtag_bitbang_test_master.sv
// Purpose: replays stored boundary-scan rows onto a board scan chain
// Assumes: rows written on clock, scan chain pins driven on link_clock
// Notes: two rows per test clock cycle, return compared per cycle
`timescale 1ns/10ps
`include "jtag_bb_defines.svh"

module jtag_bb_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 32
) (
   input wire logic wr_clock,
   input wire logic rd_clock,
   input wire logic rstn,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [WIDTH-1:0] wr_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [WIDTH-1:0] rd_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wbin_ff, rbin_ff, wgray_ff, rgray_ff;
   logic [AW:0] wg_s1_ff, wg_s2_ff, rg_s1_ff, rg_s2_ff;
   logic [AW:0] nxt_wbin, nxt_rbin;
   // full: write gray equals read gray with top two bits inverted
   assign wr_ready = (wgray_ff != {~rg_s2_ff[AW:AW-1], rg_s2_ff[AW-2:0]});
   assign rd_valid = (rgray_ff != wg_s2_ff);
   assign rd_data = mem_ff[rbin_ff[AW-1:0]];
   assign nxt_wbin = wbin_ff + (AW+1)'(wr_valid && wr_ready);
   assign nxt_rbin = rbin_ff + (AW+1)'(rd_valid && rd_ready);
   always_ff @(posedge wr_clock) begin
      if (wr_valid && wr_ready) begin
         mem_ff[wbin_ff[AW-1:0]] <= wr_data;
      end
   end
   always_ff @(posedge wr_clock or negedge rstn) begin
      if (!rstn) begin
         wbin_ff <= '0;
         wgray_ff <= '0;
         rg_s1_ff <= '0;
         rg_s2_ff <= '0;
      end else begin
         wbin_ff <= nxt_wbin;
         wgray_ff <= nxt_wbin ^ (nxt_wbin >> 1);
         rg_s1_ff <= rgray_ff;
         rg_s2_ff <= rg_s1_ff;
      end
   end
   always_ff @(posedge rd_clock or negedge rstn) begin
      if (!rstn) begin
         rbin_ff <= '0;
         rgray_ff <= '0;
         wg_s1_ff <= '0;
         wg_s2_ff <= '0;
      end else begin
         rbin_ff <= nxt_rbin;
         rgray_ff <= nxt_rbin ^ (nxt_rbin >> 1);
         wg_s1_ff <= wgray_ff;
         wg_s2_ff <= wg_s1_ff;
      end
   end
endmodule

module jtag_bitbang_test_master (
   input wire logic clock,
   input wire logic rstn,
   input wire logic link_clock,
   input wire logic master_enable,
   input wire logic row_valid,
   output logic row_ready,
   input wire logic row_tck,
   input wire logic row_tms,
   input wire logic row_tdi,
   input wire logic row_expect,
   input wire logic run_start,
   input wire logic [`JBB_LEN_W-1:0] run_length,
   output logic run_busy,
   output logic run_done,
   output logic run_mismatch,
   output logic run_format_error,
   output logic master_mode_select,
   output logic master_test_clock_out,
   output logic master_mode_select_out,
   output logic master_serial_data_out,
   input wire logic master_serial_data_return
);
   import jtag_bb_pkg::*;
   // ---------------- system clock side ----------------
   logic mode_ff, start_tgl_ff, ack_s1_ff, ack_s2_ff;
   logic [`JBB_LEN_W-1:0] len_hold_ff;
   logic [2:0] st_s1_ff, st_s2_ff;
   logic pending;
   logic [`JBB_ROW_W-1:0] row_word;

   assign pending = (start_tgl_ff != ack_s2_ff);
   assign row_word = {row_tck, row_tms, row_tdi, row_expect};
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mode_ff <= 1'b0;
      end else begin
         mode_ff <= master_enable;
      end
   end
   assign master_mode_select = mode_ff;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         start_tgl_ff <= 1'b0;
         len_hold_ff <= `JBB_LEN_RST;
      end else if (run_start && !pending && !run_busy) begin
         start_tgl_ff <= ~start_tgl_ff;
         len_hold_ff <= run_length;
      end
   end
   // status levels and start acknowledge from link side
   logic [2:0] link_status;
   logic ack_tgl_ff;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ack_s1_ff <= 1'b0;
         ack_s2_ff <= 1'b0;
         st_s1_ff <= 3'h0;
         st_s2_ff <= 3'h0;
      end else begin
         ack_s1_ff <= ack_tgl_ff;
         ack_s2_ff <= ack_s1_ff;
         st_s1_ff <= link_status;
         st_s2_ff <= st_s1_ff;
      end
   end
   assign run_busy = st_s2_ff[0] | pending;
   assign run_done = st_s2_ff[1] & ~pending;
   assign run_mismatch = st_s2_ff[2] & ~pending;
   // ---------------- pattern buffer ----------------
   logic rd_valid, rd_ready;
   logic [`JBB_ROW_W-1:0] rd_row;
   jtag_bb_fifo #(
      .WIDTH(`JBB_ROW_W),
      .DEPTH(`JBB_FIFO_DEPTH)
   ) u_fifo (
      .wr_clock(clock),
      .rd_clock(link_clock),
      .rstn(rstn),
      .wr_valid(row_valid),
      .wr_ready(row_ready),
      .wr_data(row_word),
      .rd_valid(rd_valid),
      .rd_ready(rd_ready),
      .rd_data(rd_row)
   );
   // ---------------- link clock side ----------------
   logic sg_s1_ff, sg_s2_ff, sg_s3_ff, ret_s1_ff, ret_s2_ff;
   logic start_seen;
   state_t state_ff, nxt_state;
   logic tck_ff, tms_ff, tdi_ff, exp_ff, sample_ff;
   logic busy_ff, done_ff, mism_ff, fmt_ff;
   logic [`JBB_LEN_W-1:0] len_ff;
   logic [1:0] wait_ff;
   always_ff @(posedge link_clock or negedge rstn) begin
      if (!rstn) begin
         sg_s1_ff <= 1'b0;
         sg_s2_ff <= 1'b0;
         sg_s3_ff <= 1'b0;
         ret_s1_ff <= 1'b0;
         ret_s2_ff <= 1'b0;
      end else begin
         sg_s1_ff <= start_tgl_ff;
         sg_s2_ff <= sg_s1_ff;
         sg_s3_ff <= sg_s2_ff;
         ret_s1_ff <= master_serial_data_return;
         ret_s2_ff <= ret_s1_ff;
      end
   end
   assign start_seen = (sg_s2_ff != sg_s3_ff);
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         st_idle: nxt_state = start_seen ? st_row1 : st_idle;
         st_row1: nxt_state = rd_valid ? st_row2 : st_row1;
         st_row2: nxt_state = rd_valid ? st_wait : st_row2;
         st_wait: nxt_state = (wait_ff == 2'h0) ? st_check : st_wait;
         st_check: begin
            if (sample_ff != exp_ff || len_ff == `JBB_LEN_RST) begin
               nxt_state = st_idle;
            end else begin
               nxt_state = st_row1;
            end
         end
         default: nxt_state = st_idle;
      endcase
   end
   assign rd_ready = (state_ff == st_row1) || (state_ff == st_row2);
   always_ff @(posedge link_clock or negedge rstn) begin
      if (!rstn) begin
         state_ff <= st_idle;
      end else begin
         state_ff <= nxt_state;
      end
   end
   // pin drivers: clock and mode fan out, data enters the chain
   always_ff @(posedge link_clock or negedge rstn) begin
      if (!rstn) begin
         tck_ff <= 1'b0;
         tms_ff <= 1'b0;
         tdi_ff <= 1'b0;
         exp_ff <= 1'b0;
      end else if (state_ff == st_row1 && rd_valid) begin
         tck_ff <= 1'b1;
      end else if (state_ff == st_row2 && rd_valid) begin
         tck_ff <= 1'b0;
         tms_ff <= rd_row[`JBB_ROW_TMS];
         tdi_ff <= rd_row[`JBB_ROW_TDI];
         exp_ff <= rd_row[`JBB_ROW_EXP];
      end
   end
   assign master_test_clock_out = tck_ff;
   assign master_mode_select_out = tms_ff;
   assign master_serial_data_out = tdi_ff;
   // settle wait, then capture the return line
   always_ff @(posedge link_clock or negedge rstn) begin
      if (!rstn) begin
         wait_ff <= 2'h0;
         sample_ff <= 1'b0;
      end else if (state_ff == st_row2) begin
         wait_ff <= `JBB_RETURN_WAIT;
      end else if (state_ff == st_wait) begin
         wait_ff <= wait_ff - 2'h1;
         sample_ff <= ret_s2_ff;
      end
   end
   always_ff @(posedge link_clock or negedge rstn) begin
      if (!rstn) begin
         len_ff <= `JBB_LEN_RST;
      end else if (state_ff == st_idle && start_seen) begin
         len_ff <= len_hold_ff;
      end else if (state_ff == st_check && len_ff != `JBB_LEN_RST) begin
         len_ff <= len_ff - `JBB_LEN_W'(1);
      end
   end
   // status: busy, done, sticky mismatch, row format fault
   always_ff @(posedge link_clock or negedge rstn) begin
      if (!rstn) begin
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         mism_ff <= 1'b0;
         fmt_ff <= 1'b0;
         ack_tgl_ff <= 1'b0;
      end else if (state_ff == st_idle && start_seen) begin
         busy_ff <= 1'b1;
         done_ff <= 1'b0;
         mism_ff <= 1'b0;
         fmt_ff <= 1'b0;
         ack_tgl_ff <= sg_s2_ff;
      end else begin
         if (state_ff == st_check && sample_ff != exp_ff) begin
            mism_ff <= 1'b1;
            busy_ff <= 1'b0;
         end else if (state_ff == st_check && len_ff == `JBB_LEN_RST) begin
            done_ff <= 1'b1;
            busy_ff <= 1'b0;
         end
         if (rd_valid && ((state_ff == st_row1 && !rd_row[`JBB_ROW_TCK]) ||
                          (state_ff == st_row2 && rd_row[`JBB_ROW_TCK]))) begin
            fmt_ff <= 1'b1;
         end
      end
   end
   assign link_status = {mism_ff, done_ff, busy_ff};
   logic fmt_s1_ff, fmt_s2_ff;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fmt_s1_ff <= 1'b0;
         fmt_s2_ff <= 1'b0;
      end else begin
         fmt_s1_ff <= fmt_ff;
         fmt_s2_ff <= fmt_s1_ff;
      end
   end
   assign run_format_error = fmt_s2_ff & ~pending;
   // ---------------- checks ----------------
   mode_follow_a: assert property (@(posedge clock) disable iff (!rstn)
      $past(rstn) |-> master_mode_select == $past(master_enable))
      else $error("mode select does not follow enable");
   rise_hold_a: assert property (@(posedge link_clock) disable iff (!rstn)
      (state_ff == st_row1 && rd_valid) |=> tck_ff && $stable(tms_ff) && $stable(tdi_ff))
      else $error("first row changed mode or data");
   fall_set_a: assert property (@(posedge link_clock) disable iff (!rstn)
      (state_ff == st_row2 && rd_valid) |=>
      !tck_ff && tms_ff == $past(rd_row[`JBB_ROW_TMS]) && tdi_ff == $past(rd_row[`JBB_ROW_TDI]))
      else $error("second row not applied");
   two_rows_a: assert property (@(posedge link_clock) disable iff (!rstn)
      $rose(tck_ff) |-> $past(state_ff) == st_row1 && state_ff == st_row2)
      else $error("clock cycle not built from two rows");
   sample_late_a: assert property (@(posedge link_clock) disable iff (!rstn)
      (state_ff == st_row2 && rd_valid) |=> state_ff == st_wait [*4] ##1 state_ff == st_check)
      else $error("return sampled too early");
   stop_miss_a: assert property (@(posedge link_clock) disable iff (!rstn)
      (state_ff == st_check && sample_ff != exp_ff) |=> mism_ff && state_ff == st_idle)
      else $error("mismatch did not stop playback");
   count_end_a: assert property (@(posedge link_clock) disable iff (!rstn)
      (state_ff == st_check && sample_ff == exp_ff && len_ff != `JBB_LEN_RST) |=>
      state_ff == st_row1 && len_ff == $past(len_ff) - `JBB_LEN_W'(1))
      else $error("playback ended early");
   idle_low_a: assert property (@(posedge link_clock) disable iff (!rstn)
      (state_ff == st_idle) |-> !tck_ff ##1 (state_ff != st_idle || $stable(tms_ff)))
      else $error("idle clock not low or outputs moved");
   read_pins_a: assert property (@(posedge link_clock) disable iff (!rstn)
      (state_ff == st_wait) |=> sample_ff == $past(ret_s2_ff))
      else $error("return line not captured");
endmodule

// ===== logic/jtag_bb_defines.svh
// Purpose: constants for the scan pattern player
// Assumes: included by bare name
// Notes: row layout is {clock, mode, data, expected}
`ifndef JTAG_BB_DEFINES_SVH
`define JTAG_BB_DEFINES_SVH
`define JBB_ROW_W 4
`define JBB_FIFO_DEPTH 32
`define JBB_ROW_TCK 3
`define JBB_ROW_TMS 2
`define JBB_ROW_TDI 1
`define JBB_ROW_EXP 0
`define JBB_LEN_W 16
`define JBB_LEN_RST 16'h0000
`define JBB_RETURN_WAIT 2'h3
`endif

// ===== logic/jtag_bb_pkg.sv
// Purpose: types for the scan pattern player
// Assumes: nothing
// Notes: states are one-hot
package jtag_bb_pkg;
   typedef enum logic [4:0] {
      st_idle = 5'b0_0001,
      st_row1 = 5'b0_0010,
      st_row2 = 5'b0_0100,
      st_wait = 5'b0_1000,
      st_check = 5'b1_0000
   } state_t;
endpackage

// ===== verification/tap_chain_model.sv
// Purpose: scan chain of board devices behind the pattern player
// Assumes: test clock idles low between cycles
// Notes: serial path is a plain delay of DEPTH stages
`timescale 1ns/10ps
module tap_chain_model #(
   parameter int DEPTH = 3
) (
   input wire logic rstn,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo
);
   logic [DEPTH-1:0] chain_ff;
   logic [2:0] tms_run_ff;
   // capture on rising test clock, data daisy chained
   always_ff @(posedge tck or negedge rstn) begin
      if (!rstn) begin
         chain_ff <= '0;
      end else begin
         chain_ff <= {chain_ff[DEPTH-2:0], tdi};
      end
   end
   // state steps on captured mode value
   always_ff @(posedge tck or negedge rstn) begin
      if (!rstn) begin
         tms_run_ff <= 3'h0;
      end else if (!tms) begin
         tms_run_ff <= 3'h0;
      end else if (tms_run_ff != 3'h5) begin
         tms_run_ff <= tms_run_ff + 3'h1;
      end
   end
   // return changes only on falling test clock
   always_ff @(negedge tck or negedge rstn) begin
      if (!rstn) begin
         tdo <= 1'b0;
      end else begin
         tdo <= chain_ff[DEPTH-1];
      end
   end
endmodule

// ===== verification/jtag_bitbang_test_master_tb.sv
// Purpose: self-checking bench for the scan pattern player
// Assumes: three-stage chain model at the pins
// Notes: expected returns come from a queue model of the chain
`timescale 1ns/10ps
`include "jtag_bb_defines.svh"
module jtag_bitbang_test_master_tb;
   logic clock = 0, link_clock = 0, rstn = 0, master_enable = 0, row_valid = 0;
   logic row_tck = 0, row_tms = 0, row_tdi = 0, row_expect = 0, run_start = 0;
   logic [`JBB_LEN_W-1:0] run_length = 16'h0000;
   logic row_ready, run_busy, run_done, run_mismatch, run_format_error, master_mode_select;
   logic master_test_clock_out, master_mode_select_out, master_serial_data_out;
   logic master_serial_data_return;
   int seed = 92213, miscompares = 0, n_checks = 0, rises = 0;
   bit sr_q[$] = '{0, 0, 0};
   bit tdi_q[$];
   bit cur_tms, cur_tdi;
   always #25 clock = ~clock;
   initial begin
      #7;
      forever #40 link_clock = ~link_clock;
   end
   jtag_bitbang_test_master dut (.clock, .rstn, .link_clock, .master_enable, .row_valid,
      .row_ready, .row_tck, .row_tms, .row_tdi, .row_expect, .run_start, .run_length, .run_busy,
      .run_done, .run_mismatch, .run_format_error, .master_mode_select, .master_test_clock_out,
      .master_mode_select_out, .master_serial_data_out, .master_serial_data_return);
   tap_chain_model #(.DEPTH(3)) chain (.rstn, .tck(master_test_clock_out),
      .tms(master_mode_select_out), .tdi(master_serial_data_out),
      .tdo(master_serial_data_return));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic push(input logic [3:0] r);
      int n;
      n = 0;
      @(negedge clock);
      {row_tck, row_tms, row_tdi, row_expect} = r;
      row_valid = 1;
      while (row_ready !== 1'b1 && n < 5000) begin
         @(negedge clock);
         n++;
      end
      if (n >= 5000) miscompares++;
      @(posedge clock);
   endtask
   // one test clock: row with clock high, then row with new mode and data
   task automatic cyc(input bit bad);
      bit m, d, e;
      m = 1'($random(seed));
      d = 1'($random(seed));
      tdi_q.push_back(cur_tdi);
      sr_q.push_back(cur_tdi);
      void'(sr_q.pop_front());
      e = sr_q[0] ^ bad;
      push({1'b1, 2'($random(seed)), 1'b0});
      push({1'b0, m, d, e});
      cur_tms = m;
      cur_tdi = d;
   endtask
   task automatic go(input int len);
      rises = 0;
      @(negedge clock);
      run_length = 16'(len);
      run_start = 1;
      @(negedge clock);
      chk("busy", 1, run_busy);
      run_length = 16'(len + 5);
      @(negedge clock);
      run_start = 0;
   endtask
   task automatic fin(input string name, input bit dn, input bit mm, input int cnt);
      int n;
      n = 0;
      @(negedge clock);
      row_valid = 0;
      while ((run_busy !== 1'b0 || (run_done !== 1'b1 && run_mismatch !== 1'b1)) && n < 9000) begin
         @(negedge clock);
         n++;
      end
      chk("done", dn, run_done);
      chk("mismatch", mm, run_mismatch);
      chk("test clocks", 16'(cnt), 16'(rises));
      chk("idle clock", 0, master_test_clock_out);
      chk("format clean", 0, run_format_error);
      if (!mm) begin
         chk("idle mode", cur_tms, master_mode_select_out);
         chk("idle data", cur_tdi, master_serial_data_out);
      end
      $display("test %s finished", name);
   endtask
   always @(posedge master_test_clock_out) begin
      rises++;
      if (tdi_q.size() > 0) chk("data at rise", tdi_q.pop_front(), master_serial_data_out);
   end
   initial begin
      #3_000_000;
      miscompares++;
      complete_run;
   end
   initial begin
      int len;
      repeat (4) @(negedge clock);
      rstn = 1;
      chk("ready after reset", 1, row_ready);
      master_enable = 1;
      @(negedge clock);
      chk("mode select", 1, master_mode_select);
      for (int i = 0; i < 16; i++) cyc(0);
      @(negedge clock);
      row_valid = 0;
      chk("ready when full", 0, row_ready);
      go(15);
      fin("full", 1, 0, 16);
      for (int k = 0; k < 4; k++) begin
         len = (k == 0) ? 0 : ($random(seed) & 63);
         go(len);
         for (int i = 0; i <= len; i++) cyc(0);
         fin("stream", 1, 0, len + 1);
      end
      go(9);
      for (int i = 0; i < 10; i++) cyc(i == 4);
      fin("mismatch", 0, 1, 5);
      rstn = 0;
      repeat (4) @(negedge clock);
      rstn = 1;
      sr_q = '{0, 0, 0};
      tdi_q = {};
      cur_tms = 0;
      cur_tdi = 0;
      chk("mismatch after reset", 0, run_mismatch);
      chk("ready after reset", 1, row_ready);
      master_enable = 0;
      @(negedge clock);
      chk("mode select", 0, master_mode_select);
      push(4'b0000);
      push(4'b1000);
      @(negedge clock);
      row_valid = 0;
      go(0);
      for (int n = 0; n < 400 && run_format_error !== 1'b1; n++) @(negedge clock);
      chk("format error", 1, run_format_error);
      $display("test format finished");
      complete_run;
   end
endmodule
